/* File: core/pwr_pkg.sv */
package pwr_pkg;
   // register offsets (byte addresses, word aligned)
   localparam logic [7:0] REG_MODE_CTRL = 8'h00;
   localparam logic [7:0] REG_CLK_CTRL = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_RESET_CAUSE = 8'h0c;
   localparam logic [7:0] REG_IRQ_STATUS = 8'h10;
   localparam logic [7:0] REG_IRQ_ENABLE = 8'h14;
   localparam logic [7:0] REG_IRQ_CLEAR = 8'h18;
   localparam logic [7:0] REG_WAKE_ENABLE = 8'h1c;
   localparam logic [7:0] REG_SC_CTRL = 8'h20;
   // mode request encoding, bits [1:0] of mode control
   localparam logic [1:0] MODE_ACTIVE = 2'h0;
   localparam logic [1:0] MODE_IDLE = 2'h1;
   localparam logic [1:0] MODE_STANDBY = 2'h2;
   localparam logic [1:0] MODE_SHUTDOWN = 2'h3;
   // low-speed source select, bits [1:0] of clock control; bit 2 enables clock out
   localparam logic [1:0] LSRC_RC = 2'h0;
   localparam logic [1:0] LSRC_XTAL = 2'h1;
   localparam logic [1:0] LSRC_PIN = 2'h2;
   localparam int CLK_OUT_BIT = 2;
   // reset cause codes
   localparam logic [1:0] RST_POWER_ON = 2'h0;
   localparam logic [1:0] RST_PIN = 2'h1;
   localparam logic [1:0] RST_PIN_WAKE = 2'h2;
   // interrupt status bits
   localparam int IRQ_WAKE_BIT = 0;
   localparam int IRQ_ENTER_BIT = 1;
   localparam int IRQ_W = 2;
   // wake source enable bits (standby)
   localparam int WAKE_EXT_BIT = 0;
   localparam int WAKE_RTC_BIT = 1;
   localparam int WAKE_SC_BIT = 2;
   localparam int WAKE_BATMON_BIT = 3;
   localparam int WAKE_W = 4;
   // reset values
   localparam logic [3:0] WAKE_EN_RST = 4'h7;
   localparam logic [2:0] CLK_CTRL_RST = 3'h0;
   // timing: settle time for restored logic before latch release
   localparam int CLK_HZ = 50_000_000;
   localparam int SETTLE_NS = 100;
   localparam int SETTLE_CYC = (SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

   typedef enum logic [2:0] {
      ST_ACTIVE,
      ST_WAIT_HALT,
      ST_IDLE,
      ST_STANDBY,
      ST_SHUTDOWN,
      ST_RESTORE
   } pm_state_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

   typedef struct packed {
      logic cpu_clk_en;
      logic mem_clk_en;
      logic periph_clk_en;
      logic periph_pwr_en;
      logic aon_pwr_en;
      logic sc_pwr_en;
   } pwr_ctrl_t;
endpackage : pwr_pkg

/* File: core/power_mode_clock_manager.sv */
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/100ps
// Behaviour
// - active: cpu and enabled peripherals clocked
// - idle: cpu and memory clocks stopped
// - any interrupt wakes idle to active
// - standby: only always-on and sensor controller domains powered
// - standby wake: external, rtc, sensor events
// - standby wake resumes cpu, retention kept
// - standby holds all i/o latched
// - shutdown: all off, i/o latched
// - shutdown wake pin change triggers reset
// - reset cause register shows pin wake until the system reset, which reloads power-on
// - shutdown keeps only latched i/o state
// - sensor processor autonomous, can wake cpu
// - medium-speed clock always from rc oscillator
// - low-speed clock feeds rtc, radio timer
// - low-speed source: rc, crystal or pin
// - clock out only from crystal or rc
// - battery monitor events can wake standby
module power_mode_clock_manager #(
   parameter int IO_W = 8,
   parameter int SETTLE = pwr_pkg::SETTLE_CYC
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // register port
   input wire pwr_pkg::reg_req_t req_i,
   output logic [31:0] rdata_o,
   // cpu handshake and wake events
   input wire logic cpu_halted_i,
   input wire logic irq_any_i,
   input wire logic wake_ext_i,
   input wire logic wake_rtc_i,
   input wire logic wake_sc_i,
   input wire logic wake_batmon_i,
   input wire logic reset_pin_seen_i,
   // io pins and shutdown wake pins
   input wire logic [IO_W-1:0] io_in_i,
   input wire logic [IO_W-1:0] io_drive_i,
   input wire logic [IO_W-1:0] wake_pin_sel_i,
   output logic [IO_W-1:0] io_out_o,
   output logic io_latched_o,
   // clocks in
   input wire logic ls_rc_clk_i,
   input wire logic ls_xtal_clk_i,
   input wire logic ls_pin_clk_i,
   input wire logic medium_speed_rc_osc_i,
   // clocks and power out
   output logic medium_speed_sys_clk_o,
   output logic low_speed_sys_clk_o,
   output logic ls_clk_pin_o,
   output logic ls_clk_pin_oe_o,
   output pwr_pkg::pwr_ctrl_t pwr_o,
   output logic sc_periph_cpu_own_o,
   output logic wake_reset_o,
   output logic irq_o
);
   initial begin
      if (IO_W < 1 || IO_W > 32) begin
         $error("IO_W out of range");
      end
      if (SETTLE < 1 || SETTLE > 255) begin
         $error("SETTLE out of range");
      end
   end

   // synchronisers for asynchronous inputs
   logic ms_s1_r, ms_s2_r;
   logic [IO_W-1:0] io_s1_r, io_s2_r;
   logic [2:0] ck_s1_r, ck_s2_r;
   logic [3:0] wk_s1_r, wk_s2_r;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ms_s1_r <= 1'b0;
         ms_s2_r <= 1'b0;
      end else begin
         ms_s1_r <= medium_speed_rc_osc_i;
         ms_s2_r <= ms_s1_r;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         io_s1_r <= '0;
         io_s2_r <= '0;
      end else begin
         io_s1_r <= io_in_i;
         io_s2_r <= io_s1_r;
      end
   end

   // oscillator levels are sampled, not forwarded as true clocks
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ck_s1_r <= '0;
         ck_s2_r <= '0;
      end else begin
         ck_s1_r <= {ls_pin_clk_i, ls_xtal_clk_i, ls_rc_clk_i};
         ck_s2_r <= ck_s1_r;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wk_s1_r <= '0;
         wk_s2_r <= '0;
      end else begin
         wk_s1_r <= {wake_batmon_i, wake_sc_i, wake_rtc_i, wake_ext_i};
         wk_s2_r <= wk_s1_r;
      end
   end

   function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] off);
      reg_hit = (a == off);
   endfunction : reg_hit

   // control state
   pwr_pkg::pm_state_t st_r, st_nxt;
   logic [1:0] mode_req_r, mode_req_nxt;
   logic [2:0] clk_ctrl_r, clk_ctrl_nxt;
   logic [pwr_pkg::WAKE_W-1:0] wake_en_r, wake_en_nxt;
   logic [pwr_pkg::IRQ_W-1:0] irq_st_r, irq_st_nxt, irq_en_r, irq_en_nxt;
   logic [1:0] rst_cause_r, rst_cause_nxt;
   logic sc_own_r, sc_own_nxt;
   logic [IO_W-1:0] latch_r, latch_nxt;
   logic latched_r, latched_nxt;
   logic [7:0] settle_r, settle_nxt;
   logic wake_rst_r, wake_rst_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic stby_wake, pin_change, enter_ev, wake_ev;

   // an event on any enabled standby source; batmon rides the same fabric
   assign stby_wake = |(wk_s2_r & wake_en_r);
   assign pin_change = |((io_s2_r ^ latch_r) & wake_pin_sel_i);

   always_comb begin
      st_nxt = st_r;
      mode_req_nxt = mode_req_r;
      clk_ctrl_nxt = clk_ctrl_r;
      wake_en_nxt = wake_en_r;
      irq_en_nxt = irq_en_r;
      rst_cause_nxt = rst_cause_r;
      sc_own_nxt = sc_own_r;
      latch_nxt = latch_r;
      latched_nxt = latched_r;
      settle_nxt = settle_r;
      wake_rst_nxt = 1'b0;
      rdata_nxt = '0;
      enter_ev = 1'b0;
      wake_ev = 1'b0;
      case (st_r)
         pwr_pkg::ST_ACTIVE: begin
            if (mode_req_r != pwr_pkg::MODE_ACTIVE) begin
               st_nxt = pwr_pkg::ST_WAIT_HALT;
            end
         end

         pwr_pkg::ST_WAIT_HALT: begin
            if (mode_req_r == pwr_pkg::MODE_ACTIVE) begin
               st_nxt = pwr_pkg::ST_ACTIVE;
            end else if (cpu_halted_i) begin
               enter_ev = 1'b1;
               if (mode_req_r == pwr_pkg::MODE_IDLE) begin
                  st_nxt = pwr_pkg::ST_IDLE;
               end else begin
                  // capture pins a cycle before power drops
                  latch_nxt = io_drive_i;
                  latched_nxt = 1'b1;
                  st_nxt = (mode_req_r == pwr_pkg::MODE_STANDBY) ?
                     pwr_pkg::ST_STANDBY : pwr_pkg::ST_SHUTDOWN;
               end
            end
         end

         pwr_pkg::ST_IDLE: begin
            if (irq_any_i) begin
               st_nxt = pwr_pkg::ST_ACTIVE;
               mode_req_nxt = pwr_pkg::MODE_ACTIVE;
               wake_ev = 1'b1;
            end
         end

         pwr_pkg::ST_STANDBY: begin
            if (stby_wake) begin
               st_nxt = pwr_pkg::ST_RESTORE;
               settle_nxt = 8'(SETTLE);
            end
         end

         pwr_pkg::ST_SHUTDOWN: begin
            // only a wake pin gets out; the wake is a full reset
            // repeats while a pin differs; the system reset ends it
            if (pin_change) begin
               wake_rst_nxt = 1'b1;
               rst_cause_nxt = pwr_pkg::RST_PIN_WAKE;
            end
         end

         pwr_pkg::ST_RESTORE: begin
            // latches held until restored logic settles
            if (settle_r == 8'h00) begin
               latched_nxt = 1'b0;
               st_nxt = pwr_pkg::ST_ACTIVE;
               mode_req_nxt = pwr_pkg::MODE_ACTIVE;
               wake_ev = 1'b1;
            end else begin
               settle_nxt = settle_r - 8'h01;
            end
         end
         default: begin
            st_nxt = pwr_pkg::ST_ACTIVE;
         end
      endcase

      if (reset_pin_seen_i) begin
         rst_cause_nxt = pwr_pkg::RST_PIN;
      end

      // register writes; mode taken only in active so an entry is never torn
      if (req_i.wr) begin
         if (reg_hit(req_i.addr, pwr_pkg::REG_MODE_CTRL) && st_r == pwr_pkg::ST_ACTIVE) begin
            mode_req_nxt = req_i.wdata[1:0];
         end
         if (reg_hit(req_i.addr, pwr_pkg::REG_CLK_CTRL)) begin
            clk_ctrl_nxt = req_i.wdata[2:0];
         end
         if (reg_hit(req_i.addr, pwr_pkg::REG_IRQ_ENABLE)) begin
            irq_en_nxt = req_i.wdata[pwr_pkg::IRQ_W-1:0];
         end
         if (reg_hit(req_i.addr, pwr_pkg::REG_WAKE_ENABLE)) begin
            wake_en_nxt = req_i.wdata[pwr_pkg::WAKE_W-1:0];
         end
         if (reg_hit(req_i.addr, pwr_pkg::REG_SC_CTRL)) begin
            sc_own_nxt = req_i.wdata[0];
         end
      end

      // sticky status: set beats clear
      irq_st_nxt = irq_st_r;
      if (req_i.wr && reg_hit(req_i.addr, pwr_pkg::REG_IRQ_CLEAR)) begin
         irq_st_nxt = irq_st_r & ~req_i.wdata[pwr_pkg::IRQ_W-1:0];
      end
      if (wake_ev) begin
         irq_st_nxt[pwr_pkg::IRQ_WAKE_BIT] = 1'b1;
      end
      if (enter_ev) begin
         irq_st_nxt[pwr_pkg::IRQ_ENTER_BIT] = 1'b1;
      end

      // register reads
      if (req_i.rd) begin
         case (req_i.addr)
            pwr_pkg::REG_MODE_CTRL: rdata_nxt = {30'h0, mode_req_r};
            pwr_pkg::REG_CLK_CTRL: rdata_nxt = {29'h0, clk_ctrl_r};
            pwr_pkg::REG_STATUS: rdata_nxt = {28'h0, latched_r, 3'(st_r)};
            pwr_pkg::REG_RESET_CAUSE: rdata_nxt = {30'h0, rst_cause_r};
            pwr_pkg::REG_IRQ_STATUS: rdata_nxt = {30'h0, irq_st_r};
            pwr_pkg::REG_IRQ_ENABLE: rdata_nxt = {30'h0, irq_en_r};
            pwr_pkg::REG_WAKE_ENABLE: rdata_nxt = {28'h0, wake_en_r};
            pwr_pkg::REG_SC_CTRL: rdata_nxt = {31'h0, sc_own_r};
            default: begin
               rdata_nxt = '0;
            end
         endcase
      end
   end

   // states in which the cpu may fetch
   function automatic logic cpu_runs(input pwr_pkg::pm_state_t s);
      cpu_runs = (s == pwr_pkg::ST_ACTIVE || s == pwr_pkg::ST_WAIT_HALT);
   endfunction : cpu_runs

   // clock select and gates
   logic ls_sel, ls_out_ok;
   pwr_pkg::pwr_ctrl_t pwr_nxt;
   logic [IO_W-1:0] io_out_nxt;

   always_comb begin
      case (clk_ctrl_r[1:0])
         pwr_pkg::LSRC_XTAL: begin
            ls_sel = ck_s2_r[1];
         end
         pwr_pkg::LSRC_PIN: begin
            ls_sel = ck_s2_r[2];
         end
         default: begin
            ls_sel = ck_s2_r[0];
         end
      endcase
      // a pin-sourced clock is never echoed back out
      ls_out_ok = clk_ctrl_r[pwr_pkg::CLK_OUT_BIT] &&
         clk_ctrl_r[1:0] != pwr_pkg::LSRC_PIN;

      // gates follow the state a cycle late, so pins latch first
      pwr_nxt.cpu_clk_en = cpu_runs(st_r);
      pwr_nxt.mem_clk_en = pwr_nxt.cpu_clk_en;
      pwr_nxt.periph_clk_en = cpu_runs(st_r) || st_r == pwr_pkg::ST_IDLE;
      pwr_nxt.periph_pwr_en = (st_r != pwr_pkg::ST_STANDBY && st_r != pwr_pkg::ST_SHUTDOWN);
      pwr_nxt.aon_pwr_en = (st_r != pwr_pkg::ST_SHUTDOWN);
      pwr_nxt.sc_pwr_en = (st_r != pwr_pkg::ST_SHUTDOWN);
      io_out_nxt = latched_r ? latch_r : io_drive_i;
   end

   // sequencer state
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_r <= pwr_pkg::ST_ACTIVE;
         latch_r <= '0;
         latched_r <= 1'b0;
         settle_r <= '0;
         wake_rst_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         latch_r <= latch_nxt;
         latched_r <= latched_nxt;
         settle_r <= settle_nxt;
         wake_rst_r <= wake_rst_nxt;
      end
   end

   // software-visible registers
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mode_req_r <= pwr_pkg::MODE_ACTIVE;
         clk_ctrl_r <= pwr_pkg::CLK_CTRL_RST;
         wake_en_r <= pwr_pkg::WAKE_EN_RST;
         irq_st_r <= '0;
         irq_en_r <= '0;
         rst_cause_r <= pwr_pkg::RST_POWER_ON;
         sc_own_r <= 1'b0;
         rdata_r <= '0;
      end else begin
         mode_req_r <= mode_req_nxt;
         clk_ctrl_r <= clk_ctrl_nxt;
         wake_en_r <= wake_en_nxt;
         irq_st_r <= irq_st_nxt;
         irq_en_r <= irq_en_nxt;
         rst_cause_r <= rst_cause_nxt;
         sc_own_r <= sc_own_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // registered outputs
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pwr_o <= '1;
         io_out_o <= '0;
         medium_speed_sys_clk_o <= 1'b0;
         low_speed_sys_clk_o <= 1'b0;
         ls_clk_pin_o <= 1'b0;
         ls_clk_pin_oe_o <= 1'b0;
         irq_o <= 1'b0;
      end else begin
         pwr_o <= pwr_nxt;
         io_out_o <= io_out_nxt;
         medium_speed_sys_clk_o <= ms_s2_r;
         low_speed_sys_clk_o <= ls_sel;
         ls_clk_pin_o <= ls_out_ok & ls_sel;
         ls_clk_pin_oe_o <= ls_out_ok;
         irq_o <= |(irq_st_nxt & irq_en_r);
      end
   end

   assign rdata_o = rdata_r;
   assign io_latched_o = latched_r;
   assign wake_reset_o = wake_rst_r;
   assign sc_periph_cpu_own_o = sc_own_r;
endmodule : power_mode_clock_manager

/* File: verification/pm_sva.sv */
`timescale 1ns/100ps
module pm_sva #(
   parameter int IO_W = 8
) (
   // clock, reset and register port
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire pwr_pkg::reg_req_t req_i,
   input wire logic [31:0] rdata_o,
   // watched pins
   input wire logic irq_any_i,
   input wire logic [IO_W-1:0] io_out_o,
   input wire logic io_latched_o,
   input wire pwr_pkg::pwr_ctrl_t pwr_o,
   input wire logic wake_reset_o,
   input wire logic irq_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   property p_rd_quiet; !req_i.rd |=> rdata_o == 32'h0; endproperty
   a_rd_quiet: assert property (p_rd_quiet) else $error("read data left standing");
   property p_run; pwr_o.cpu_clk_en |-> pwr_o.mem_clk_en && pwr_o.periph_pwr_en; endproperty
   a_run: assert property (p_run) else $error("cpu clocked without memory");
   // bound is slack: restore drops periph_clk_en, so only an idle exit matches, within 2 cycles
   property p_idle_wake;
      pwr_o.periph_clk_en && !pwr_o.cpu_clk_en && irq_any_i |-> ##[1:8] pwr_o.cpu_clk_en;
   endproperty
   a_idle_wake: assert property (p_idle_wake) else $error("idle not left");
   property p_aon; !pwr_o.periph_pwr_en |-> !pwr_o.periph_clk_en && !pwr_o.cpu_clk_en; endproperty
   a_aon: assert property (p_aon) else $error("clock left on in standby");
   property p_shut;
      !pwr_o.aon_pwr_en |-> !pwr_o.sc_pwr_en && !pwr_o.periph_pwr_en && io_latched_o;
   endproperty
   a_shut: assert property (p_shut) else $error("shutdown not complete");
   property p_hold; io_latched_o && $past(io_latched_o) |-> $stable(io_out_o); endproperty
   a_hold: assert property (p_hold) else $error("latched pins moved");
   property p_release; $fell(io_latched_o) |-> pwr_o.periph_pwr_en && pwr_o.aon_pwr_en; endproperty
   a_release: assert property (p_release) else $error("latch freed before power");
   property p_wrst; wake_reset_o |-> !pwr_o.aon_pwr_en && io_latched_o; endproperty
   a_wrst: assert property (p_wrst) else $error("wake reset outside shutdown");
   property p_mask;
      req_i.wr && req_i.addr == pwr_pkg::REG_IRQ_ENABLE && req_i.wdata[1:0] == 2'h0
         |-> ##2 !irq_o;
   endproperty
   a_mask: assert property (p_mask) else $error("masked interrupt still high");
endmodule : pm_sva
bind power_mode_clock_manager pm_sva #(.IO_W(IO_W)) u_sva (.clk_i(clk_i), .rst_n_i(rst_n_i),
   .req_i(req_i), .rdata_o(rdata_o), .irq_any_i(irq_any_i), .io_out_o(io_out_o),
   .io_latched_o(io_latched_o), .pwr_o(pwr_o), .wake_reset_o(wake_reset_o), .irq_o(irq_o));

/* File: verification/cpu_model.sv */
`timescale 1ns/100ps
module cpu_model #(
   parameter int HALT_DLY = 4
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // software view
   input wire pwr_pkg::reg_req_t req_i,
   input wire logic cpu_clk_en_i,
   output logic cpu_halted_o
);
   int cnt_r;
   logic off_r;
   // mode written first, halt a few cycles later so early entry shows
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_r <= 0;
         off_r <= 1'b0;
         cpu_halted_o <= 1'b0;
      end else begin
         if (req_i.wr && req_i.addr == pwr_pkg::REG_MODE_CTRL && req_i.wdata[1:0] != 2'h0) begin
            cnt_r <= HALT_DLY;
         end else if (cnt_r > 0) begin
            cnt_r <= cnt_r - 1;
         end
         if (cnt_r == 1) begin
            cpu_halted_o <= 1'b1;
         end
         if (!cpu_clk_en_i) begin
            off_r <= 1'b1;
         end
         if (cpu_clk_en_i && off_r) begin
            off_r <= 1'b0;
            cpu_halted_o <= 1'b0;
         end
      end
   end
endmodule : cpu_model

/* File: verification/tb_power_mode_clock_manager.sv */
`timescale 1ns/100ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin err_total++; \
   $display("BAD %s exp %h got %h", nm, e, g); end end
`define WAITC(c) begin for (wk = 0; wk < 300 && (c) !== 1'b1; wk++) @(posedge clk_i) #1; \
   if ((c) !== 1'b1) begin err_total++; $display("BAD wait exp 1 got 0"); end_of_test(); end end
module tb_power_mode_clock_manager;
   typedef struct packed {logic [2:0] ctl; logic [2:0] src; logic oe; logic ls;} row_t;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   pwr_pkg::reg_req_t req_i = '0;
   logic [31:0] rdata_o, v;
   logic halted, ms_clk, ls_clk, oe, ls_pin, sc_own, latched, wake_rst, irq_o;
   logic irq_any = 1'b0;
   logic pin_rst = 1'b0;
   logic mso = 1'b0;
   logic [3:0] wake_v = 4'h0;
   logic [2:0] src = 3'h0;
   logic [7:0] io_in = 8'h00, io_drv = 8'h00, io_out;
   pwr_pkg::pwr_ctrl_t pwr_o;
   int err_total = 0, num_checks = 0, wk, i;
   // source levels are rc, xtal, pin
   row_t rows [5] = '{'{3'h4, 3'h4, 1, 1}, '{3'h5, 3'h4, 1, 0}, '{3'h6, 3'h1, 0, 1},
      '{3'h1, 3'h2, 0, 1}, '{3'h0, 3'h3, 0, 0}};
   always #10 clk_i = ~clk_i;
   cpu_model cpu (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req_i),
      .cpu_clk_en_i(pwr_o.cpu_clk_en), .cpu_halted_o(halted));
   power_mode_clock_manager DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req_i),
      .rdata_o(rdata_o), .cpu_halted_i(halted), .irq_any_i(irq_any), .wake_ext_i(wake_v[0]),
      .wake_rtc_i(wake_v[1]), .wake_sc_i(wake_v[2]), .wake_batmon_i(wake_v[3]),
      .reset_pin_seen_i(pin_rst), .io_in_i(io_in), .io_drive_i(io_drv),
      .wake_pin_sel_i(8'h01), .io_out_o(io_out), .io_latched_o(latched),
      .ls_rc_clk_i(src[2]), .ls_xtal_clk_i(src[1]), .ls_pin_clk_i(src[0]),
      .medium_speed_rc_osc_i(mso), .medium_speed_sys_clk_o(ms_clk), .low_speed_sys_clk_o(ls_clk),
      .ls_clk_pin_o(ls_pin), .ls_clk_pin_oe_o(oe), .pwr_o(pwr_o), .sc_periph_cpu_own_o(sc_own),
      .wake_reset_o(wake_rst), .irq_o(irq_o));
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      req_i <= '{a, d, 1'b1, 1'b0};
      @(posedge clk_i);
      req_i <= '0;
      @(posedge clk_i) #1;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      req_i <= '{a, 32'h0, 1'b0, 1'b1};
      @(posedge clk_i) #1;
      v = rdata_o;
      req_i <= '0;
      @(posedge clk_i) #1;
   endtask : rd
   task automatic rst();
      rst_n_i <= 1'b0;
      repeat (12) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i) #1;
   endtask : rst
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : end_of_test
   initial begin
      rst();
      `CHK("pwr", 6'h3f, pwr_o)
      rd(pwr_pkg::REG_WAKE_ENABLE);
      `CHK("wake_en", {28'h0, pwr_pkg::WAKE_EN_RST}, v)
      rd(pwr_pkg::REG_RESET_CAUSE);
      `CHK("cause", {30'h0, pwr_pkg::RST_POWER_ON}, v)
      rd(8'h3c);
      `CHK("unmapped", 32'h0, v)
      wr(pwr_pkg::REG_STATUS, 32'hff);
      rd(pwr_pkg::REG_STATUS);
      `CHK("status", 32'h0, v)
      $display("test reset done");
      foreach (rows[k]) begin
         src <= rows[k].src;
         mso <= ~rows[k].ls;
         wr(pwr_pkg::REG_CLK_CTRL, {29'h0, rows[k].ctl});
         repeat (6) @(posedge clk_i);
         rd(pwr_pkg::REG_CLK_CTRL);
         `CHK("clk_ctrl", {29'h0, rows[k].ctl}, v)
         `CHK("ls_clk", rows[k].ls, ls_clk)
         `CHK("ms_clk", ~rows[k].ls, ms_clk)
         `CHK("clk_oe", rows[k].oe, oe)
         `CHK("clk_pin", rows[k].oe & rows[k].ls, ls_pin)
      end
      wr(pwr_pkg::REG_SC_CTRL, 32'h1);
      `CHK("sc_own", 1'b1, sc_own)
      $display("test clocks done");
      wr(pwr_pkg::REG_MODE_CTRL, {30'h0, pwr_pkg::MODE_IDLE});
      `WAITC(!pwr_o.cpu_clk_en)
      `CHK("idle", 2'b01, {pwr_o.mem_clk_en, pwr_o.periph_clk_en})
      irq_any <= 1'b1;
      `WAITC(pwr_o.cpu_clk_en)
      irq_any <= 1'b0;
      $display("test idle done");
      for (i = 0; i < 4; i++) begin
         io_drv <= 8'h5a;
         wr(pwr_pkg::REG_WAKE_ENABLE, 32'h1 << i);
         wr(pwr_pkg::REG_MODE_CTRL, {30'h0, pwr_pkg::MODE_STANDBY});
         `CHK("early", 1'b0, latched)
         `WAITC(!pwr_o.periph_pwr_en)
         io_drv <= 8'ha5;
         `CHK("stby", 5'h01, pwr_o[5:1])
         wake_v <= 4'h1 << ((i + 1) % 4);
         repeat (8) @(posedge clk_i) #1;
         `CHK("stray", 1'b1, latched)
         `CHK("held", 8'h5a, io_out)
         wake_v <= 4'h1 << i;
         `WAITC(!latched)
         wake_v <= 4'h0;
         @(posedge clk_i) #1;
         `CHK("resume", 6'h3f, pwr_o)
      end
      wr(pwr_pkg::REG_IRQ_ENABLE, 32'h1);
      `CHK("irq_on", 1'b1, irq_o)
      wr(pwr_pkg::REG_IRQ_ENABLE, 32'h0);
      `CHK("irq_mask", 1'b0, irq_o)
      wr(pwr_pkg::REG_IRQ_CLEAR, 32'h3);
      rd(pwr_pkg::REG_IRQ_STATUS);
      `CHK("irq_clr", 1'b0, v[0])
      $display("test standby done");
      io_drv <= 8'h00;
      wr(pwr_pkg::REG_MODE_CTRL, {30'h0, pwr_pkg::MODE_SHUTDOWN});
      `WAITC(!pwr_o.aon_pwr_en)
      `CHK("shut", 10'h100, {pwr_o.sc_pwr_en, latched, io_out})
      io_in <= 8'h01;
      `WAITC(wake_rst)
      rd(pwr_pkg::REG_RESET_CAUSE);
      `CHK("cause_wake", {30'h0, pwr_pkg::RST_PIN_WAKE}, v)
      io_in <= 8'h00;
      rst();
      rd(pwr_pkg::REG_RESET_CAUSE);
      `CHK("cause_lost", {30'h0, pwr_pkg::RST_POWER_ON}, v)
      pin_rst <= 1'b1;
      @(posedge clk_i) #1;
      pin_rst <= 1'b0;
      rd(pwr_pkg::REG_RESET_CAUSE);
      `CHK("cause_pin", {30'h0, pwr_pkg::RST_PIN}, v)
      $display("test shutdown done");
      end_of_test();
   end
endmodule : tb_power_mode_clock_manager
